// *** logic/serial_rx.sv ***
// Serial receiver with nine-bit characters and address detect
// Assumes one 40 MHz clock, a plain register port and a serial input pin
//
// Overview of operation
// - Nine-bit mode captures nine bits; ninth lands in received_ninth_bit.
// - Address detect needs address_detect_enable (bit 3) plus nine-bit mode.
// - Address detect: buffer loaded only and flag set only when ninth bit one.
// - Data characters under address detect are not buffered and raise nothing.
// - Ignored character in the shift register is overwritten by the next one.
// - Address detect does nothing in eight-bit mode.
// - Without address detect every character is accepted; ninth bit for software.
// - continuous_receive_enable at bit 4 starts continuous reception.
// - single_receive_enable also arms the receiver.
// - Completion sets receive_flag; interrupt only with receive_irq_enable.
// - Reading receive_data returns the low eight buffered bits.
// - Clearing continuous_receive_enable clears pending errors.
// - Sync select chooses mode; port works only with serial_port_enable.
// - Baud from baud_divisor; high_baud_select picks the fast range.
// - Clearing address detect and flag restores reception of all characters.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "serial_rx_regs.svh"

module serial_rx (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // Serial line
   input  wire logic       rx_pin,
   // Interrupt
   output logic            irq
);
   import serial_rx_pkg::*;

   // ------------------------------------------------------------------
   // Limitations
   // ------------------------------------------------------------------
   // Reception goes on after an overrun; the buffer keeps the older
   // character until software reads it, and the newer one is dropped.
   // Sync mode has no clock pin here: it only shortens the bit time,
   // so the far side must pace the line at that rate.
   // Start detection waits for a baud tick, so with a large divisor the
   // sample point drifts late by up to one tick; keep the divisor small
   // against the oversampling count.
   // A framing error on a character that address detect ignores is
   // not reported, since nothing of that character is kept.
   // single_receive_enable clears itself after one character unless
   // continuous reception is also on.
   // Transmit control is storage only, apart from the sync select and
   // baud range bits that shape the receive timing.

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Register address compare, shared by the write and read decode
   function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction : reg_hit

   // One step of a down counter that rests at zero
   function automatic logic [5:0] count_down(input logic [5:0] n);
      return (n == 6'd0) ? 6'd0 : n - 6'd1;
   endfunction : count_down

   // Ticks per bit less one: sync timing wins over the baud range select
   function automatic logic [5:0] ticks_per_bit(input logic sync_sel, input logic fast);
      if (sync_sel) begin
         return `SYNC_BIT_TICKS;
      end else if (fast) begin
         return `OVERSAMPLE_HIGH;
      end
      return `OVERSAMPLE_LOW;
   endfunction : ticks_per_bit

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   logic [7:0] ctrl_reg;
   logic [7:0] txctl_reg;
   logic [7:0] div_reg;
   logic [7:0] ien_reg;
   logic [7:0] data_reg;
   logic       ninth_reg;
   logic       flag_reg;
   logic       framing_error_flag_reg;
   logic       overrun_error_flag_reg;
   logic       sync1_reg;
   logic       sync2_reg;
   rx_state_t  state_reg;
   logic [7:0] baud_cnt_reg;
   logic [5:0] tick_cnt_reg;
   logic [3:0] bit_cnt_reg;
   logic [8:0] shift_reg;

   // ------------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------------
   wire hit_ctrl  = reg_hit(addr, `OFF_RX_STAT_CTRL);
   wire hit_flags = reg_hit(addr, `OFF_IRQ_FLAGS);
   wire hit_data  = reg_hit(addr, `OFF_RX_DATA);
   wire hit_ien   = reg_hit(addr, `OFF_IRQ_ENABLES);
   wire hit_txctl = reg_hit(addr, `OFF_TX_STAT_CTRL);
   wire hit_div   = reg_hit(addr, `OFF_BAUD_DIVISOR);

   wire port_en   = ctrl_reg[`BIT_SERIAL_PORT_EN];
   wire nine_bit  = ctrl_reg[`BIT_NINE_BIT_RX];
   wire cont_en   = ctrl_reg[`BIT_CONT_RX];
   wire single_en = ctrl_reg[`BIT_SINGLE_RX];
   wire sync_mode = txctl_reg[`BIT_SYNC_SELECT];
   wire high_baud = txctl_reg[`BIT_HIGH_BAUD];
   wire addr_mode = ctrl_reg[`BIT_ADDR_DETECT] & nine_bit;
   // either enable arms, port must be on
   wire armed     = port_en & (cont_en | single_en);

   // ------------------------------------------------------------------
   // Baud ticks
   // ------------------------------------------------------------------
   // divisor sets tick rate, range picks samples per bit
   wire       tick      = armed && baud_cnt_reg == 8'h00;
   wire [5:0] bit_ticks = ticks_per_bit(sync_mode, high_baud);
   wire [5:0] half_ticks = {1'b0, bit_ticks[5:1]};
   wire       rx_line   = sync2_reg;

   // ------------------------------------------------------------------
   // Receive sequencer
   // ------------------------------------------------------------------
   wire [3:0] last_bit  = nine_bit ? 4'd8 : 4'd7;
   wire       at_sample = tick && tick_cnt_reg == 6'd0;
   wire       done      = state_reg == RX_STOP && at_sample;
   // accept unless detect and ninth bit zero
   wire       accept    = !addr_mode | shift_reg[8];
   wire       load      = done & accept;

   // Two stages: the pin is asynchronous to clk
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= rx_pin;
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         baud_cnt_reg <= 8'h00;
      end else if (!armed || baud_cnt_reg == 8'h00) begin
         baud_cnt_reg <= div_reg;
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 8'h01;
      end
   end

   rx_state_t  state_next;
   logic [5:0] tick_cnt_next;
   logic [3:0] bit_cnt_next;
   logic [8:0] shift_next;

   always_comb begin
      state_next    = state_reg;
      tick_cnt_next = tick_cnt_reg;
      bit_cnt_next  = bit_cnt_reg;
      shift_next    = shift_reg;
      if (!armed) begin
         state_next = RX_IDLE;
      end else if (tick) begin
         case (state_reg)
            RX_IDLE: begin
               // Wait half a bit to land mid start bit
               if (!rx_line) begin
                  state_next    = RX_START;
                  tick_cnt_next = half_ticks;
               end
            end
            RX_START: begin
               if (tick_cnt_reg != 6'd0) begin
                  tick_cnt_next = count_down(tick_cnt_reg);
               end else if (rx_line) begin
                  // False start: line went back high
                  state_next = RX_IDLE;
               end else begin
                  state_next    = RX_DATA;
                  tick_cnt_next = bit_ticks;
                  bit_cnt_next  = 4'd0;
                  // next character overwrites an ignored one
                  shift_next    = 9'h000;
               end
            end
            RX_DATA: begin
               if (tick_cnt_reg != 6'd0) begin
                  tick_cnt_next = count_down(tick_cnt_reg);
               end else begin
                  // bits placed by index, ninth into bit 8
                  shift_next[bit_cnt_reg] = rx_line;
                  tick_cnt_next = bit_ticks;
                  bit_cnt_next  = bit_cnt_reg + 4'd1;
                  if (bit_cnt_reg == last_bit) begin
                     state_next = RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               // One more bit time, then the stop bit is sampled
               if (tick_cnt_reg != 6'd0) begin
                  tick_cnt_next = count_down(tick_cnt_reg);
               end else begin
                  state_next = RX_IDLE;
               end
            end
            default: state_next = RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg    <= RX_IDLE;
         tick_cnt_reg <= 6'd0;
         bit_cnt_reg  <= 4'd0;
         shift_reg    <= 9'h000;
      end else begin
         state_reg    <= state_next;
         tick_cnt_reg <= tick_cnt_next;
         bit_cnt_reg  <= bit_cnt_next;
         shift_reg    <= shift_next;
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   // Status bits 2..0 belong to the receiver, so writes never reach them
   wire [7:0] ctrl_mask  = 8'hf8;
   // Bit 1 of transmit control reads as one: no transmitter sits here
   wire [7:0] txctl_mask = 8'hf5;
   wire [7:0] txctl_set  = 8'h02;
   wire [7:0] ien_mask   = 8'hf7;
   wire [7:0] single_clr = ~(8'h01 << `BIT_SINGLE_RX);

   // A software write wins over the self-clear of a single reception
   wire       single_done = done && single_en && !cont_en;
   wire [7:0] ctrl_next   = (wr && hit_ctrl) ? (wdata & ctrl_mask) :
                            single_done      ? (ctrl_reg & single_clr) : ctrl_reg;
   wire [7:0] txctl_next  = (wr && hit_txctl) ? ((wdata & txctl_mask) | txctl_set) : txctl_reg;
   wire [7:0] div_next    = (wr && hit_div) ? wdata : div_reg;
   wire [7:0] ien_next    = (wr && hit_ien) ? (wdata & ien_mask) : ien_reg;

   // One register per block keeps each reset value plain
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `RST_RX_STAT_CTRL;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txctl_reg <= `RST_TX_STAT_CTRL;
      end else begin
         txctl_reg <= txctl_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div_reg <= `RST_BAUD_DIVISOR;
      end else begin
         div_reg <= div_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ien_reg <= `RST_IRQ_ENABLES;
      end else begin
         ien_reg <= ien_next;
      end
   end

   // ------------------------------------------------------------------
   // Buffer and flags
   // ------------------------------------------------------------------
   wire clr_cont  = wr && hit_ctrl && !wdata[`BIT_CONT_RX];
   wire read_data = rd && hit_data;
   // Writing a one to the receive flag clears it; a data read does too
   wire clr_flag  = (wr && hit_flags && wdata[`BIT_RX_FLAG]) || read_data;
   wire stop_bad  = done && !rx_line;

   // Set wins over a clear in the same cycle
   // completion sets flag
   wire flag_set  = load && !flag_reg;
   wire flag_next = flag_set ? 1'b1 : (clr_flag ? 1'b0 : flag_reg);
   // framing on low stop bit, cleared by the next good character
   wire framing_error_flag_set  = stop_bad && accept;
   wire framing_error_flag_clr  = clr_cont || (load && rx_line);
   wire framing_error_flag_next = framing_error_flag_set ? 1'b1 : (framing_error_flag_clr ? 1'b0 : framing_error_flag_reg);
   // overrun while buffer full; cleared with continuous enable
   wire overrun_error_flag_set  = load && flag_reg;
   wire overrun_error_flag_next = overrun_error_flag_set ? 1'b1 : (clr_cont ? 1'b0 : overrun_error_flag_reg);

   // Buffer keeps the older character while the flag is still up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_reg  <= 8'h00;
         ninth_reg <= 1'b0;
      end else if (flag_set) begin
         data_reg  <= shift_reg[7:0];
         ninth_reg <= shift_reg[8];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         framing_error_flag_reg <= 1'b0;
      end else begin
         framing_error_flag_reg <= framing_error_flag_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         overrun_error_flag_reg <= 1'b0;
      end else begin
         overrun_error_flag_reg <= overrun_error_flag_next;
      end
   end

   // ------------------------------------------------------------------
   // Read data and interrupt
   // ------------------------------------------------------------------
   wire [7:0] ctrl_view = {ctrl_reg[7:3], framing_error_flag_reg, overrun_error_flag_reg, ninth_reg};
   // Only the receive flag lives in this register here
   wire [7:0] flag_view = {2'b00, flag_reg, 5'b00000};
   wire [7:0] rd_mux = hit_ctrl  ? ctrl_view :
                       hit_flags ? flag_view :
                       hit_data  ? data_reg  :
                       hit_ien   ? ien_reg   :
                       hit_txctl ? txctl_reg :
                       hit_div   ? div_reg   : 8'h00;

   // Read data stand one cycle after the strobe, zero otherwise
   wire [7:0] rdata_next = rd ? rd_mux : 8'h00;
   wire       irq_next   = flag_reg & ien_reg[`BIT_RX_IRQ_EN];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= 8'h00;
         irq   <= 1'b0;
      end else begin
         rdata <= rdata_next;
         irq   <= irq_next;
      end
   end

endmodule : serial_rx

// *** pkg/serial_rx_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes byte-wide registers reached over a plain strobe port
`ifndef SERIAL_RX_REGS_SVH
`define SERIAL_RX_REGS_SVH

// ------------------------------------------------------------------
// Offsets
// ------------------------------------------------------------------
`define OFF_IRQ_FLAGS     8'h0c
`define OFF_RX_STAT_CTRL  8'h18
`define OFF_RX_DATA       8'h1a
`define OFF_IRQ_ENABLES   8'h8c
`define OFF_TX_STAT_CTRL  8'h98
`define OFF_BAUD_DIVISOR  8'h99

// ------------------------------------------------------------------
// Fields
// ------------------------------------------------------------------
`define BIT_SERIAL_PORT_EN  7
`define BIT_NINE_BIT_RX     6
`define BIT_SINGLE_RX       5
`define BIT_CONT_RX         4
`define BIT_ADDR_DETECT     3
`define BIT_FRAMING_ERR     2
`define BIT_OVERRUN_ERR     1
`define BIT_RX_NINTH        0
`define BIT_RX_FLAG         5
`define BIT_RX_IRQ_EN       5
`define BIT_SYNC_SELECT     4
`define BIT_HIGH_BAUD       2
`define BIT_TX_EMPTY        1

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_RX_STAT_CTRL  8'h00
`define RST_TX_STAT_CTRL  8'h02
`define RST_BAUD_DIVISOR  8'h00
`define RST_IRQ_ENABLES   8'h00

// ------------------------------------------------------------------
// Timing: ticks per bit, less one, for each baud range and sync mode
// ------------------------------------------------------------------
`define OVERSAMPLE_LOW    6'd63
`define OVERSAMPLE_HIGH   6'd15
`define SYNC_BIT_TICKS    6'd3

`endif

// *** pkg/serial_rx_pkg.sv ***
// Types shared by the serial receiver
// Assumes the constants header is compiled alongside
package serial_rx_pkg;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : serial_rx_pkg

// *** dv/serial_rx_properties.sv ***
// Port-level checks for the serial receiver
// Assumes it is bound to serial_rx and sees only its ports
`timescale 1ns/1ps
module serial_rx_properties (
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // Serial line and interrupt
   input wire logic       rx_pin,
   input wire logic       irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Cycles since the line was last low; an irq rise must follow a frame
   logic [9:0] quiet_cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) quiet_cnt <= 10'h000;
      else if (!rx_pin) quiet_cnt <= 10'h000;
      else if (quiet_cnt != 10'h3ff) quiet_cnt <= quiet_cnt + 10'h001;
   end
   property p_rdata_idle; !$past(rd) |-> rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not zero");
   property p_unmapped; rd && !(addr inside {8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99}) |=> rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_irq_off_en; wr && addr == 8'h8c && !wdata[5] |-> ##2 !irq; endproperty
   a_irq_off_en: assert property (p_irq_off_en) else $error("irq with enable off");
   property p_irq_off_read; rd && addr == 8'h1a |-> ##2 !irq; endproperty
   a_irq_off_read: assert property (p_irq_off_read) else $error("irq after data read");
   property p_irq_off_flag; wr && addr == 8'h0c && wdata[5] |-> ##2 !irq; endproperty
   a_irq_off_flag: assert property (p_irq_off_flag) else $error("irq after flag clear");
   property p_irq_hold;
      $fell(irq) |-> $past(rd && addr == 8'h1a, 2) || $past(wr && addr inside {8'h0c, 8'h18, 8'h8c}, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
   property p_tx_empty; rd && addr == 8'h98 |=> rdata[1]; endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("tx empty bit low");
   property p_irq_after_char; $rose(irq) && !$past(wr && addr == 8'h8c, 2) |-> quiet_cnt < 10'd900; endproperty
   a_irq_after_char: assert property (p_irq_after_char) else $error("irq without frame");
   property p_reset_out; $fell(rst) |-> !irq && rdata == 8'h00; endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not clear at reset");
   c_data_read: cover property (rd && addr == 8'h1a ##1 rdata != 8'h00);
   c_irq_rise: cover property ($rose(irq));
   c_irq_fall: cover property ($fell(irq));
endmodule : serial_rx_properties

// *** dv/serial_master.sv ***
// Master processor model driving the serial line
// Assumes bit time in clk cycles is given per character
`timescale 1ns/1ps
module serial_master (
   // Clock
   input wire logic clk,
   // Serial line, idle high
   output logic     line
);
   initial line = 1'b1;
   // ninth bit one marks an address
   task automatic send(input logic [8:0] ch, input logic nine, input int bt, input logic stop_ok);
      logic [10:0] f;
      f = {stop_ok, ch, 1'b0};
      if (!nine) f[9] = stop_ok;
      @(posedge clk);
      for (int i = 0; i < (nine ? 11 : 10); i++) begin
         line <= f[i];
         repeat (bt) @(posedge clk);
      end
      // Gap lets the receiver settle before the next frame
      line <= 1'b1;
      repeat (2 * bt) @(posedge clk);
   endtask : send
endmodule : serial_master

// *** dv/tb_top.sv ***
// Self-checking bench for the serial receiver
// Assumes serial_rx, its checker and the master model are compiled first
`timescale 1ns/1ps
module tb_top;
   logic       clk   = 1'b0;
   logic       rst   = 1'b1;
   logic [7:0] addr  = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr    = 1'b0;
   logic       rd    = 1'b0;
   logic [7:0] rdata;
   logic       rx_pin;
   logic       irq;
   int         err_count = 0;
   int         n_tests   = 0;
   logic [15:0] rst_tab [7] = '{16'h0c00, 16'h1800, 16'h1a00, 16'h8c00, 16'h9802, 16'h9900, 16'h5500};
   logic [23:0] baud_tab [3] = '{24'h040120, 24'h000040, 24'h140108};
   always #12.5 clk = ~clk;
   serial_rx dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                    .rdata(rdata), .rx_pin(rx_pin), .irq(irq));
   serial_master partner_u (.clk(clk), .line(rx_pin));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg_%h", a), rdata & m, e);
   endtask : rd_chk
   task automatic rx(input logic [8:0] ch, input logic nine, input int bt, input logic got);
      partner_u.send(ch, nine, bt, 1'b1);
      chk("irq", {7'h00, irq}, {7'h00, got});
      if (got) rd_chk(8'h1a, 8'hff, ch[7:0]);
   endtask : rx
   task automatic end_of_test();
      $display("Checks made %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      foreach (rst_tab[i]) rd_chk(rst_tab[i][15:8], 8'hff, rst_tab[i][7:0]);
      wr_reg(8'h99, 8'h5a);
      rd_chk(8'h99, 8'hff, 8'h5a);
      wr_reg(8'h1a, 8'hff);
      rd_chk(8'h1a, 8'hff, 8'h00);
      wr_reg(8'h99, 8'h00);
      wr_reg(8'h98, 8'h04);
      wr_reg(8'h8c, 8'h20);
      wr_reg(8'h18, 8'h90);
      rx(9'h0a5, 1'b0, 16, 1'b1);
      wr_reg(8'h18, 8'hd0);
      rx(9'h05a, 1'b1, 16, 1'b1);
      rd_chk(8'h18, 8'hff, 8'hd0);
      rx(9'h1c3, 1'b1, 16, 1'b1);
      rd_chk(8'h18, 8'hff, 8'hd1);
      wr_reg(8'h18, 8'hd8);
      rx(9'h011, 1'b1, 16, 1'b0);
      rd_chk(8'h0c, 8'hff, 8'h00);
      rx(9'h022, 1'b1, 16, 1'b0);
      rx(9'h1a7, 1'b1, 16, 1'b1);
      rd_chk(8'h18, 8'hff, 8'hd9);
      wr_reg(8'h18, 8'hd0);
      rx(9'h066, 1'b1, 16, 1'b1);
      wr_reg(8'h18, 8'he0);
      partner_u.send(9'h177, 1'b1, 16, 1'b1);
      chk("irq", {7'h00, irq}, 8'h01);
      wr_reg(8'h0c, 8'h20);
      rd_chk(8'h18, 8'hff, 8'hc1);
      wr_reg(8'h18, 8'h98);
      rx(9'h144, 1'b0, 16, 1'b1);
      wr_reg(8'h8c, 8'h00);
      rx(9'h081, 1'b0, 16, 1'b0);
      rd_chk(8'h0c, 8'h20, 8'h20);
      rd_chk(8'h1a, 8'hff, 8'h81);
      wr_reg(8'h8c, 8'h20);
      wr_reg(8'h18, 8'h10);
      rx(9'h055, 1'b0, 16, 1'b0);
      rd_chk(8'h0c, 8'hff, 8'h00);
      foreach (baud_tab[i]) begin
         wr_reg(8'h98, baud_tab[i][23:16]);
         wr_reg(8'h99, baud_tab[i][15:8]);
         wr_reg(8'h18, 8'h90);
         rx(9'h03c, 1'b0, int'(baud_tab[i][7:0]), 1'b1);
      end
      wr_reg(8'h98, 8'h04);
      wr_reg(8'h99, 8'h00);
      partner_u.send(9'h0f0, 1'b0, 16, 1'b0);
      rd_chk(8'h18, 8'h04, 8'h04);
      wr_reg(8'h18, 8'h80);
      rd_chk(8'h18, 8'h06, 8'h00);
      wr_reg(8'h0c, 8'h20);
      wr_reg(8'h18, 8'h90);
      partner_u.send(9'h011, 1'b0, 16, 1'b1);
      partner_u.send(9'h022, 1'b0, 16, 1'b1);
      rd_chk(8'h18, 8'h06, 8'h02);
      rd_chk(8'h1a, 8'hff, 8'h11);
      wr_reg(8'h18, 8'h80);
      rd_chk(8'h18, 8'h06, 8'h00);
      end_of_test();
   end
   // Watchdog: all traffic fits well inside this span
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      end_of_test();
   end
endmodule : tb_top
bind serial_rx serial_rx_properties chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
                                           .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .irq(irq));
